// File: dv/spfc_properties.sv
// pin-level properties of the serial port control
`timescale 1ns/1ps
`include "spfc_map.svh"
module spfc_properties
  import spfc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_WR,
  input wire logic [31:0] WB_DAT_RD,
  input wire logic WB_ACK,
  input wire logic TXD,
  input wire logic RTS_N,
  input wire logic DIFF_CONV,
  input wire logic TLOSS_FAULT,
  input wire logic IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////
  // shadow of the stored flow mode
  logic hw_r;
  wire take = WB_CYC && WB_STB && !WB_ACK;
  wire ans = WB_ACK && !WB_WE;
  wire flow_wr = take && WB_WE && WB_SEL[0] && WB_ADR == `SPFC_A_FLOW;
  wire flow_ok = WB_DAT_WR == 32'h1 || WB_DAT_WR == 32'h2;
  always_ff @(posedge SYS_CLK)
  begin
    hw_r <= RESET ? 1'b0 : (flow_wr && flow_ok) ? WB_DAT_WR[1] : hw_r;
  end
  ////////////////////////////////////////////////////////////////
  ack_one_cycle_a: assert property (WB_ACK |=> !WB_ACK)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (take |=> WB_ACK)
    else $error("ack missing after request");
  ack_cause_a: assert property (WB_ACK |-> $past(take))
    else $error("ack without request");
  rd_hold_a: assert property (!(take && !WB_WE) |=> $stable(WB_DAT_RD))
    else $error("read data moved");
  reset_idle_a: assert property (disable iff (1'b0) RESET |=>
    !WB_ACK && TXD && !RTS_N && !TLOSS_FAULT && !IRQ && WB_DAT_RD == 32'h0)
    else $error("outputs not idle after reset");
  baud_range_a: assert property (ans && WB_ADR == `SPFC_A_BAUD |-> WB_DAT_RD inside {[1:10]})
    else $error("baud code out of range");
  stn_range_a: assert property (ans && WB_ADR == `SPFC_A_STN |-> WB_DAT_RD <= 32'd30)
    else $error("station address out of range");
  tmo_range_a: assert property (ans && WB_ADR == `SPFC_A_TMO |-> WB_DAT_RD <= 32'd32)
    else $error("timeout out of range");
  flow_read_a: assert property (ans && WB_ADR == `SPFC_A_FLOW |->
    WB_DAT_RD inside {1, 2} && (!$past(DIFF_CONV) || WB_DAT_RD == 32'h1))
    else $error("flow mode reads wrong");
  rts_mode_a: assert property (RTS_N |-> hw_r && !DIFF_CONV)
    else $error("rts high outside mode 2");
  cover property (RTS_N);
  cover property ($rose(TLOSS_FAULT));
  cover property ($rose(IRQ));
  cover property ($fell(TXD) && hw_r);
endmodule : spfc_properties
////////////////////////////////////////////////////////////////
bind spfc_top spfc_properties chk (.*);

// File: dv/spfc_term.sv
// terminal model on the far side of the serial line
`timescale 1ns/1ps
module spfc_term
(
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  int div = 5;
  int nb = 9;
  bit par = 1'b1;
  int perr = 0;
  logic full = 1'b0;
  logic [8:0] c_r;
  logic [8:0] got[$];
  assign cts_n = full;
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////////
  // lsb first, even parity
  task automatic put(input logic [8:0] c);
    @(posedge clk);
    rxd <= 1'b0;
    for (int i = 0; i <= nb; i++)
    begin
      repeat (div) @(posedge clk);
      rxd <= (i == nb) ? 1'b1 : (par && i == nb - 1) ? ^(c & ((9'h1 << i) - 9'h1)) : c[i];
    end
    repeat (2 * div) @(posedge clk);
  endtask : put
  always
  begin
    @(negedge txd);
    repeat (div / 2) @(posedge clk);
    c_r = 9'h0;
    for (int i = 0; i < nb; i++)
    begin
      repeat (div) @(posedge clk);
      if (par && i == nb - 1)
        perr += (txd !== ^c_r);
      else
        c_r[i] = txd;
    end
    repeat (div) @(posedge clk);
    got.push_back(c_r);
  end
endmodule : spfc_term

// File: dv/testbench.sv
// self-checking bench of the serial port control
`timescale 1ns/1ps
`include "spfc_map.svh"
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin miscompares++; $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic dconv = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr, q;
  logic [3:0] sel = 4'hF;
  logic [15:0] sval;
  logic [15:0] e;
  logic [8:0] src, q9;
  logic ack, txd, rts_n, flt, irq, rxd, cts_n;
  int checks = 0;
  int miscompares = 0;
  int n, s, m0, m1;
  spfc_top #(.CLK_HZ(50000)) uut (.SYS_CLK(clk), .RESET(rst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
    .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_WR(dw), .WB_DAT_RD(dr), .WB_ACK(ack), .RXD(rxd), .TXD(txd),
    .CTS_N(cts_n), .RTS_N(rts_n), .DIFF_CONV(dconv), .SRC_NUM(src), .SRC_VAL(sval), .TLOSS_FAULT(flt),
    .IRQ(irq));
  spfc_term term (.clk(clk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  initial forever #10 clk = ~clk;
  // value answers the source number at once
  assign sval = srcv(src);
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] srcv(input logic [8:0] x);
    return {x[3:0], 3'h5, x};
  endfunction : srcv
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      summarize();
    end
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
    wb(a, 1'b0, 32'h0);
    `CHK(nm, x, q)
  endtask : rdc
  task automatic getc(input logic [8:0] x);
    for (n = 0; n < 4000 && term.got.size() == 0; n++) @(posedge clk);
    if (n == 4000)
    begin
      miscompares++;
      summarize();
    end
    q9 = term.got.pop_front();
    `CHK("char", x, q9)
    repeat (2 * term.div) @(posedge clk);
  endtask : getc
  ////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h95F3));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("pins", 4'h8, {txd, rts_n, flt, irq})
    rdc(`SPFC_A_PROTO, 32'h1192, "proto");
    rdc(`SPFC_A_BAUD, 32'h6, "baud");
    rdc(`SPFC_A_STN, 32'h0, "stn");
    rdc(`SPFC_A_TMO, 32'h0, "tmo");
    rdc(`SPFC_A_FLOW, 32'h1, "flow");
    rdc(`SPFC_A_PDN, 32'h0, "pdn");
    rdc(8'h3C, 32'h0, "unmapped");
    rdc(`SPFC_A_CTRL, 32'h4, "ctrl");
    $display("test reset done");
    wb(`SPFC_A_BAUD, 1'b1, 32'hA);
    wb(`SPFC_A_BAUD, 1'b1, 32'hB);
    rdc(`SPFC_A_BAUD, 32'hA, "baud max");
    wb(`SPFC_A_BAUD, 1'b1, 32'h1);
    wb(`SPFC_A_BAUD, 1'b1, 32'h0);
    rdc(`SPFC_A_BAUD, 32'h1, "baud min");
    sel <= 4'h2;
    wb(`SPFC_A_BAUD, 1'b1, 32'h7);
    sel <= 4'hF;
    rdc(`SPFC_A_BAUD, 32'h1, "baud lane");
    s = $urandom_range(30, 0);
    wb(`SPFC_A_STN, 1'b1, s);
    wb(`SPFC_A_STN, 1'b1, 32'h1F);
    rdc(`SPFC_A_STN, s, "stn");
    wb(`SPFC_A_TMO, 1'b1, 32'h20);
    wb(`SPFC_A_TMO, 1'b1, 32'h21);
    rdc(`SPFC_A_TMO, 32'h20, "tmo max");
    wb(`SPFC_A_TMO, 1'b1, 32'h0);
    wb(`SPFC_A_FLOW, 1'b1, 32'h3);
    wb(`SPFC_A_FLOW, 1'b1, 32'h0);
    rdc(`SPFC_A_FLOW, 32'h1, "flow");
    $display("test range done");
    wb(`SPFC_A_BAUD, 1'b1, 32'h5);
    wb(`SPFC_A_CTRL, 1'b1, 32'h1);
    wb(`SPFC_A_TXD, 1'b1, 32'hA5);
    getc(9'h0A5);
    wb(`SPFC_A_PROTO, 1'b1, 32'h2081);
    rdc(`SPFC_A_CTRL, 32'h5, "pending");
    wb(`SPFC_A_CTRL, 1'b1, 32'h1);
    term.div = 10;
    term.nb = 8;
    term.par = 1'b0;
    wb(`SPFC_A_TXD, 1'b1, 32'h5A);
    getc(9'h05A);
    $display("test apply done");
    wb(`SPFC_A_STAT, 1'b0, 32'h0);
    wb(`SPFC_A_MASK, 1'b1, 32'h1);
    term.put(9'h013);
    repeat (2) @(posedge clk);
    `CHK("irq set", 1'b1, irq)
    wb(`SPFC_A_STAT, 1'b0, 32'h0);
    `CHK("rx event", 1'b1, q[0])
    `CHK("irq clear", 1'b0, irq)
    rdc(`SPFC_A_CTRL, 32'h0, "permit off");
    wb(`SPFC_A_TXD, 1'b1, 32'h33);
    term.put(9'h041);
    repeat (100) @(posedge clk);
    `CHK("held", 0, term.got.size())
    term.put(9'h011);
    getc(9'h033);
    rdc(`SPFC_A_RXD, 32'h211, "rx char");
    wb(`SPFC_A_MASK, 1'b1, 32'h0);
    term.put(9'h020);
    repeat (2) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    wb(`SPFC_A_RXD, 1'b0, 32'h0);
    $display("test soft flow done");
    wb(`SPFC_A_FLOW, 1'b1, 32'h2);
    rdc(`SPFC_A_FLOW, 32'h2, "flow hw");
    term.full <= 1'b1;
    wb(`SPFC_A_TXD, 1'b1, 32'hC3);
    repeat (100) @(posedge clk);
    `CHK("cts held", 0, term.got.size())
    term.full <= 1'b0;
    getc(9'h0C3);
    term.put(9'h077);
    repeat (2) @(posedge clk);
    `CHK("rts busy", 1'b1, rts_n)
    rdc(`SPFC_A_RXD, 32'h277, "rx hw");
    `CHK("rts ready", 1'b0, rts_n)
    term.put(9'h078);
    dconv <= 1'b1;
    rdc(`SPFC_A_FLOW, 32'h1, "flow diff");
    `CHK("rts diff", 1'b0, rts_n)
    dconv <= 1'b0;
    wb(`SPFC_A_FLOW, 1'b1, 32'h1);
    $display("test hard flow done");
    wb(`SPFC_A_PROTO, 1'b1, 32'h1192);
    wb(`SPFC_A_CTRL, 1'b1, 32'h1);
    term.nb = 9;
    term.par = 1'b1;
    m0 = $urandom_range(399, 0);
    m1 = $urandom_range(399, 0);
    wb(`SPFC_A_PDN, 1'b1, 32'h2);
    wb(8'h40, 1'b1, m0);
    wb(8'h44, 1'b1, m1);
    term.put(9'(32'h80 + (s + 1) % 31));
    wb(`SPFC_A_STAT, 1'b0, 32'h0);
    `CHK("miss", 1'b0, q[2])
    term.put(9'(32'h80 + s));
    wb(`SPFC_A_STAT, 1'b0, 32'h0);
    `CHK("hit", 1'b1, q[2])
    wb(`SPFC_A_CTRL, 1'b1, 32'h2);
    e = srcv(m0);
    getc(e[15:8]);
    getc(e[7:0]);
    e = srcv(m1);
    getc(e[15:8]);
    getc(e[7:0]);
    $display("test slave done");
    wb(`SPFC_A_TMO, 1'b1, 32'h1);
    term.put(9'(32'h80 + s));
    for (n = 0; n < 52000 && flt !== 1'b1; n++) @(posedge clk);
    `CHK("loss", 1'b1, flt)
    `CHK("loss time", 1'b1, n > 49900)
    wb(`SPFC_A_STAT, 1'b0, 32'h0);
    `CHK("loss event", 1'b1, q[3])
    term.put(9'(32'h80 + s));
    repeat (2) @(posedge clk);
    `CHK("loss clear", 1'b0, flt)
    `CHK("parity", 0, term.perr)
    $display("test watchdog done");
    summarize();
  end
endmodule : testbench

// File: verilog/spfc_map.svh
// register map, field codes and timing constants of the serial port
`ifndef SPFC_MAP_SVH
`define SPFC_MAP_SVH
`define SPFC_A_PROTO 8'h00
`define SPFC_A_BAUD 8'h04
`define SPFC_A_STN 8'h08
`define SPFC_A_TMO 8'h0C
`define SPFC_A_FLOW 8'h10
`define SPFC_A_CTRL 8'h14
`define SPFC_A_TXD 8'h18
`define SPFC_A_RXD 8'h1C
`define SPFC_A_STAT 8'h20
`define SPFC_A_MASK 8'h24
`define SPFC_A_PDN 8'h28
`define SPFC_MAP_SEG 2'h1
`define SPFC_RST_PROTO 16'h1192
`define SPFC_RST_BAUD 4'h6
`define SPFC_RST_FLOW 2'h1
`define SPFC_BAUD_MAX 4'hA
`define SPFC_STN_MAX 5'h1E
`define SPFC_TMO_MAX 6'h20
`define SPFC_SRC_MAX 9'h18F
`define SPFC_PDN_MAX 5'h10
`define SPFC_XOFF 8'h13
`define SPFC_XON 8'h11
`define SPFC_FN_FREE 4'h1
`define SPFC_FN_SLAVE 4'h2
`define SPFC_FN_PBUS 4'h4
`define SPFC_FN_PEER 4'h5
`define SPFC_FN_DIAG 4'h9
`define SPFC_FRM_9 4'h9
`define SPFC_PAR_EVEN 4'h1
`define SPFC_STOP_2 4'h2
`define SPFC_FLOW_SW 2'h1
`define SPFC_FLOW_HW 2'h2
`define SPFC_CTRL_APPLY 0
`define SPFC_CTRL_SEND 1
`define SPFC_ST_RX 0
`define SPFC_ST_TXDONE 1
`define SPFC_ST_HIT 2
`define SPFC_ST_LOSS 3
`define SPFC_ST_ERR 4
`define SPFC_NSTAT 5
`define SPFC_CLK_HZ 50000000
`define SPFC_WD_STEP_S 1
`define SPFC_BAUD_1 300
`define SPFC_BAUD_2 600
`define SPFC_BAUD_3 1200
`define SPFC_BAUD_4 2400
`define SPFC_BAUD_5 4800
`define SPFC_BAUD_6 9600
`define SPFC_BAUD_7 19200
`define SPFC_BAUD_8 38400
`define SPFC_BAUD_9 93750
`define SPFC_BAUD_10 187500
`endif

// File: verilog/spfc_pkg.sv
// state types of the serial port
package spfc_pkg;
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} spfc_tx_t;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} spfc_rx_t;
  typedef enum logic [2:0] {SQ_IDLE, SQ_BYTE, SQ_ADDR, SQ_LOAD, SQ_HI, SQ_LO} spfc_seq_t;
endpackage : spfc_pkg

// File: verilog/spfc_ser_if.sv
// character link between port control and bit engine
`timescale 1ns/1ps
interface spfc_ser_if #(parameter int DIV_W = 18);
  logic [DIV_W-1:0] div;
  logic [3:0] nbits;
  logic par_en;
  logic stop2;
  logic tx_valid;
  logic [8:0] tx_data;
  logic tx_ready;
  logic rx_valid;
  logic [8:0] rx_data;
  logic rx_perr;
  logic rx_ferr;
  modport ctl (output div, nbits, par_en, stop2, tx_valid, tx_data,
               input tx_ready, rx_valid, rx_data, rx_perr, rx_ferr);
  modport eng (input div, nbits, par_en, stop2, tx_valid, tx_data,
               output tx_ready, rx_valid, rx_data, rx_perr, rx_ferr);
endinterface : spfc_ser_if

// File: verilog/spfc_top.sv
// serial port control: settings, flow control, addressing, watchdog
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "spfc_map.svh"
// Functional notes
// [R01] baud codes 1..10, default code 6
// [R02] new baud applies after protocol change, apply
// [R03] word slots 0..15 carry mapped source 0..399
// [R04] slave answers only its station address 0..30
// [R05] slave telegram-loss fault after 1..32 s
// [R06] flow mode only for free/diagnostic protocol
// [R07] mode 1: 13H stops telegram start
// [R08] mode 1: 11H permits, others ignored
// [R09] mode 2: transmit only while CTS low
// [R10] mode 2: RTS low when ready to receive
// [R11] partner raises CTS keeping buffer reserve
// [R12] flow mode accepts 1 or 2, default 1
// [R13] four-wire converter forces flow mode 1
// [R14] 8/9-bit frame, even parity, 1/2 stops
// [R15] protocol code 2 selects slave protocol
// [R16] reset: transmit permitted, watchdog disarmed
module spfc_top
  import spfc_pkg::*;
#(
  parameter int CLK_HZ = `SPFC_CLK_HZ,
  parameter int DIV_W = 18,
  parameter int NWORDS = 16
)
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_WR,
  output logic [31:0] WB_DAT_RD,
  output logic WB_ACK,
  input wire logic RXD,
  output logic TXD,
  input wire logic CTS_N,
  output logic RTS_N,
  input wire logic DIFF_CONV,
  output logic [8:0] SRC_NUM,
  input wire logic [15:0] SRC_VAL,
  output logic TLOSS_FAULT,
  output logic IRQ
);
  localparam int SEC_CYCLES = CLK_HZ * `SPFC_WD_STEP_S;
  localparam int SEC_W = $clog2(SEC_CYCLES + 1);
  // [R01] bit period from baud code
  function automatic logic [DIV_W-1:0] baud_div(input logic [3:0] code);
    int b;
    case (code)
      4'h1: b = `SPFC_BAUD_1;
      4'h2: b = `SPFC_BAUD_2;
      4'h3: b = `SPFC_BAUD_3;
      4'h4: b = `SPFC_BAUD_4;
      4'h5: b = `SPFC_BAUD_5;
      4'h7: b = `SPFC_BAUD_7;
      4'h8: b = `SPFC_BAUD_8;
      4'h9: b = `SPFC_BAUD_9;
      4'hA: b = `SPFC_BAUD_10;
      default: b = `SPFC_BAUD_6;
    endcase
    baud_div = DIV_W'((CLK_HZ + b / 2) / b);
  endfunction : baud_div

  spfc_ser_if #(.DIV_W(DIV_W)) ser ();
  spfc_uart #(.DIV_W(DIV_W)) u_uart (
    .clk(SYS_CLK),
    .rst(RESET),
    .rxd(RXD),
    .txd(TXD),
    .ser(ser.eng)
  );
  ////////////////////////////////////////////////////////////////
  logic ack_r;
  logic [31:0] rdat_r;
  logic [15:0] proto_r;
  logic [15:0] pact_r;
  logic [3:0] baud_r;
  logic [3:0] bact_r;
  logic pend_r;
  logic [4:0] stn_r;
  logic [5:0] tmo_r;
  logic [1:0] flow_r;
  logic [4:0] pdn_r;
  logic [`SPFC_NSTAT-1:0] stat_r;
  logic [`SPFC_NSTAT-1:0] mask_r;
  logic [8:0] rxd_r;
  logic rxf_r;
  logic [8:0] txd_r;
  logic txf_r;
  logic pdreq_r;
  logic permit_r;
  logic sel_r;
  logic arm_r;
  logic [SEC_W-1:0] sc_r;
  logic [5:0] secs_r;
  logic fault_r;
  logic [8:0] map_r [NWORDS];
  logic [8:0] srcn_r;
  logic [15:0] word_r;
  logic [3:0] idx_r;
  spfc_seq_t sq_r;
  spfc_seq_t sq_nxt;
  ////////////////////////////////////////////////////////////////
  // bus decode
  wire req = WB_CYC && WB_STB && !ack_r;
  wire wr = req && WB_WE;
  wire wr0 = wr && WB_SEL[0];
  wire rd = req && !WB_WE;
  wire [15:0] lmask = {{8{WB_SEL[1]}}, {8{WB_SEL[0]}}};
  wire [15:0] proto_w = (proto_r & ~lmask) | (WB_DAT_WR[15:0] & lmask);
  wire h_proto = WB_ADR == `SPFC_A_PROTO;
  wire h_baud = WB_ADR == `SPFC_A_BAUD;
  wire h_stn = WB_ADR == `SPFC_A_STN;
  wire h_tmo = WB_ADR == `SPFC_A_TMO;
  wire h_flow = WB_ADR == `SPFC_A_FLOW;
  wire h_ctrl = WB_ADR == `SPFC_A_CTRL;
  wire h_txd = WB_ADR == `SPFC_A_TXD;
  wire h_rxd = WB_ADR == `SPFC_A_RXD;
  wire h_stat = WB_ADR == `SPFC_A_STAT;
  wire h_mask = WB_ADR == `SPFC_A_MASK;
  wire h_pdn = WB_ADR == `SPFC_A_PDN;
  wire h_map = WB_ADR[7:6] == `SPFC_MAP_SEG;
  wire [3:0] map_i = WB_ADR[5:2];
  wire map_ok = 5'(map_i) < 5'(NWORDS);
  wire apply = wr0 && h_ctrl && WB_DAT_WR[`SPFC_CTRL_APPLY] && pend_r;
  ////////////////////////////////////////////////////////////////
  // active frame and protocol fields
  wire [3:0] fn = pact_r[3:0];
  wire frm9 = pact_r[7:4] == `SPFC_FRM_9;
  wire par_en = pact_r[11:8] == `SPFC_PAR_EVEN;
  // [R15] slave protocol select
  wire slave = fn == `SPFC_FN_SLAVE;
  wire pd_mode = slave || fn == `SPFC_FN_PBUS || fn == `SPFC_FN_PEER;
  // [R06] flow control scope
  wire flow_app = fn == `SPFC_FN_FREE || fn == `SPFC_FN_DIAG;
  // [R13] converter pins mode to 1
  wire [1:0] flow_eff = DIFF_CONV ? `SPFC_FLOW_SW : flow_r;
  wire sw_fc = flow_app && flow_eff == `SPFC_FLOW_SW;
  wire hw_fc = flow_app && flow_eff == `SPFC_FLOW_HW;
  // [R14] frame shape
  assign ser.div = baud_div(bact_r);
  assign ser.nbits = frm9 ? (par_en ? 4'h8 : 4'h9) : (par_en ? 4'h7 : 4'h8);
  assign ser.par_en = par_en;
  assign ser.stop2 = pact_r[15:12] == `SPFC_STOP_2;
  ////////////////////////////////////////////////////////////////
  // receive path
  wire rxv = ser.rx_valid;
  wire [8:0] rxc = ser.rx_data;
  wire marker = (frm9 && !par_en) ? rxc[8] : rxc[7];
  // [R04] address byte carries station number
  wire adr_byte = slave && rxv && marker;
  wire hit = adr_byte && rxc[4:0] == stn_r;
  wire deliver = rxv && (!slave || (!marker && sel_r));
  wire rxd_clr = rd && h_rxd;
  ////////////////////////////////////////////////////////////////
  // watchdog, one-second steps
  wire sec_tick = sc_r == SEC_W'(SEC_CYCLES - 1);
  wire wd_on = slave && arm_r && tmo_r != 6'h00 && !fault_r;
  // [R05] timeout reached
  wire loss = wd_on && sec_tick && (secs_r + 6'h01) >= tmo_r;
  ////////////////////////////////////////////////////////////////
  // transmit sequencing
  wire go_ok = !sw_fc || permit_r;
  // [R09] CTS gates each character
  wire cts_ok = !hw_fc || !CTS_N;
  wire sq_tx = sq_r == SQ_BYTE || sq_r == SQ_HI || sq_r == SQ_LO;
  wire tx_fire = ser.tx_valid && ser.tx_ready;
  wire last_w = 5'(idx_r) == pdn_r - 5'h01;
  assign ser.tx_valid = sq_tx && cts_ok;
  assign ser.tx_data = sq_r == SQ_HI ? {1'b0, word_r[15:8]} : (sq_r == SQ_LO ? {1'b0, word_r[7:0]} : txd_r);
  wire tel_done = tx_fire && (sq_r == SQ_BYTE || (sq_r == SQ_LO && last_w));
  wire [`SPFC_NSTAT-1:0] ev;
  assign ev[`SPFC_ST_RX] = deliver;
  assign ev[`SPFC_ST_TXDONE] = tel_done;
  assign ev[`SPFC_ST_HIT] = hit;
  assign ev[`SPFC_ST_LOSS] = loss;
  assign ev[`SPFC_ST_ERR] = rxv && (ser.rx_perr || ser.rx_ferr);
  // read clears, a new event wins
  wire [`SPFC_NSTAT-1:0] stat_nxt = (stat_r & ~{`SPFC_NSTAT{rd && h_stat}}) | ev;
  always_comb
  begin
    sq_nxt = sq_r;
    case (sq_r)
      // [R07] telegram start held by XOFF
      SQ_IDLE:
        if (go_ok && txf_r)
          sq_nxt = SQ_BYTE;
        else if (go_ok && pdreq_r && pd_mode && pdn_r != 5'h00)
          sq_nxt = SQ_ADDR;
      SQ_BYTE: if (tx_fire) sq_nxt = SQ_IDLE;
      SQ_ADDR: sq_nxt = SQ_LOAD;
      SQ_LOAD: sq_nxt = SQ_HI;
      SQ_HI: if (tx_fire) sq_nxt = SQ_LO;
      SQ_LO: if (tx_fire) sq_nxt = last_w ? SQ_IDLE : SQ_ADDR;
      default: sq_nxt = SQ_IDLE;
    endcase
  end
  wire [31:0] rd_val =
    h_proto ? {16'h0, proto_r} :
    h_baud ? {28'h0, baud_r} :
    h_stn ? {27'h0, stn_r} :
    h_tmo ? {26'h0, tmo_r} :
    h_flow ? {30'h0, flow_eff} :
    h_ctrl ? {29'h0, permit_r, sq_r != SQ_IDLE, pend_r} :
    h_rxd ? {22'h0, rxf_r, rxd_r} :
    h_stat ? {27'h0, stat_r} :
    h_mask ? {27'h0, mask_r} :
    h_pdn ? {27'h0, pdn_r} :
    (h_map && map_ok) ? {23'h0, map_r[map_i]} : 32'h0;
  assign WB_ACK = ack_r;
  assign WB_DAT_RD = rdat_r;
  assign SRC_NUM = srcn_r;
  assign TLOSS_FAULT = fault_r;
  assign IRQ = |(stat_r & mask_r);
  // [R10] RTS follows receive holding space
  assign RTS_N = hw_fc ? rxf_r : 1'b0;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end
    else
    begin
      ack_r <= req;
      rdat_r <= rd ? rd_val : rdat_r;
    end
  end
  ////////////////////////////////////////////////////////////////
  // settings
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      proto_r <= `SPFC_RST_PROTO;
      pact_r <= `SPFC_RST_PROTO;
      baud_r <= `SPFC_RST_BAUD;
      bact_r <= `SPFC_RST_BAUD;
      pend_r <= 1'b0;
      stn_r <= 5'h00;
      tmo_r <= 6'h00;
      flow_r <= `SPFC_RST_FLOW;
      pdn_r <= 5'h00;
      mask_r <= '0;
    end
    else
    begin
      // [R02] protocol change arms, apply takes effect
      if (wr && h_proto && proto_w != proto_r)
      begin
        proto_r <= proto_w;
        pend_r <= 1'b1;
      end
      else if (apply)
        pend_r <= 1'b0;
      if (apply)
      begin
        pact_r <= proto_r;
        bact_r <= baud_r;
      end
      // [R01] codes outside 1..10 ignored
      if (wr0 && h_baud && WB_DAT_WR[3:0] != 4'h0 && WB_DAT_WR[3:0] <= `SPFC_BAUD_MAX && WB_DAT_WR[31:4] == 28'h0)
        baud_r <= WB_DAT_WR[3:0];
      if (wr0 && h_stn && WB_DAT_WR[7:0] <= 8'(`SPFC_STN_MAX))
        stn_r <= WB_DAT_WR[4:0];
      if (wr0 && h_tmo && WB_DAT_WR[7:0] <= 8'(`SPFC_TMO_MAX))
        tmo_r <= WB_DAT_WR[5:0];
      // [R12] only 1 or 2 accepted
      if (wr0 && h_flow && (WB_DAT_WR == 32'(`SPFC_FLOW_SW) || WB_DAT_WR == 32'(`SPFC_FLOW_HW)))
        flow_r <= WB_DAT_WR[1:0];
      if (wr0 && h_pdn && WB_DAT_WR[7:0] <= 8'(`SPFC_PDN_MAX))
        pdn_r <= WB_DAT_WR[4:0];
      if (wr0 && h_mask)
        mask_r <= WB_DAT_WR[`SPFC_NSTAT-1:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  // [R03] source map, one entry per word slot
  genvar gi;
  for (gi = 0; gi < NWORDS; gi++)
  begin : g_map
    always_ff @(posedge SYS_CLK)
    begin
      if (RESET)
        map_r[gi] <= 9'h000;
      else if (wr && h_map && map_i == 4'(gi) && WB_SEL[1:0] == 2'h3 && WB_DAT_WR[15:0] <= 16'(`SPFC_SRC_MAX))
        map_r[gi] <= WB_DAT_WR[8:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  // data and flow state
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      stat_r <= '0;
      rxd_r <= 9'h000;
      rxf_r <= 1'b0;
      txd_r <= 9'h000;
      txf_r <= 1'b0;
      pdreq_r <= 1'b0;
      permit_r <= 1'b1;
      sel_r <= 1'b0;
      sq_r <= SQ_IDLE;
      idx_r <= 4'h0;
      srcn_r <= 9'h000;
      word_r <= 16'h0000;
    end
    else
    begin
      stat_r <= stat_nxt;
      rxd_r <= deliver ? rxc : rxd_r;
      rxf_r <= deliver || (rxf_r && !rxd_clr);
      if (wr0 && h_txd)
        txd_r <= WB_DAT_WR[8:0];
      txf_r <= (wr0 && h_txd) || (txf_r && !(sq_r == SQ_BYTE && tx_fire));
      pdreq_r <= (wr0 && h_ctrl && WB_DAT_WR[`SPFC_CTRL_SEND]) || (pdreq_r && sq_nxt != SQ_ADDR);
      // [R08] XON permits, XOFF stops, other characters ignored
      if (sw_fc && rxv && rxc[7:0] == `SPFC_XON)
        permit_r <= 1'b1;
      else if (sw_fc && rxv && rxc[7:0] == `SPFC_XOFF)
        permit_r <= 1'b0;
      if (adr_byte)
        sel_r <= hit;
      sq_r <= sq_nxt;
      if (sq_r == SQ_IDLE)
        idx_r <= 4'h0;
      else if (sq_r == SQ_LO && tx_fire)
        idx_r <= idx_r + 4'h1;
      srcn_r <= map_r[idx_r];
      if (sq_r == SQ_LOAD)
        word_r <= SRC_VAL;
    end
  end
  ////////////////////////////////////////////////////////////////
  // [R16] watchdog idle until first addressed telegram
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      arm_r <= 1'b0;
      sc_r <= '0;
      secs_r <= 6'h00;
      fault_r <= 1'b0;
    end
    else if (hit)
    begin
      arm_r <= 1'b1;
      sc_r <= '0;
      secs_r <= 6'h00;
      fault_r <= 1'b0;
    end
    else if (wd_on)
    begin
      sc_r <= sec_tick ? '0 : sc_r + 1'b1;
      secs_r <= sec_tick ? secs_r + 6'h01 : secs_r;
      fault_r <= loss;
    end
  end
endmodule : spfc_top

// File: verilog/spfc_uart.sv
// bit engine: one character out, one character in
`timescale 1ns/1ps
`include "spfc_map.svh"
module spfc_uart
  import spfc_pkg::*;
#(
  parameter int DIV_W = 18
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rxd,
  output logic txd,
  spfc_ser_if.eng ser
);
  spfc_tx_t txs_r;
  spfc_rx_t rxs_r;
  logic [DIV_W-1:0] tc_r;
  logic [DIV_W-1:0] rc_r;
  logic [3:0] tb_r;
  logic [3:0] rb_r;
  logic [8:0] ts_r;
  logic [8:0] rs_r;
  logic tp_r;
  logic rp_r;
  logic [8:0] rdat_r;
  logic rv_r;
  logic rpe_r;
  logic rfe_r;
  wire [DIV_W-1:0] div_m1 = ser.div - 1'b1;
  wire t_tick = tc_r == div_m1;
  wire r_tick = rc_r == div_m1;
  wire r_half = rc_r == (ser.div >> 1);
  wire [3:0] nb_m1 = ser.nbits - 4'h1;
  wire [8:0] mask = ser.nbits == 4'h9 ? 9'h1FF : (ser.nbits == 4'h8 ? 9'h0FF : 9'h07F);
  wire [8:0] tx_m = ser.tx_data & mask;
  wire [8:0] rx_al = rs_r >> (4'h9 - ser.nbits);
  assign ser.tx_ready = txs_r == T_IDLE;
  assign ser.rx_valid = rv_r;
  assign ser.rx_data = rdat_r;
  assign ser.rx_perr = rpe_r;
  assign ser.rx_ferr = rfe_r;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txs_r <= T_IDLE;
      tc_r <= '0;
      tb_r <= 4'h0;
      ts_r <= 9'h000;
      tp_r <= 1'b0;
      txd <= 1'b1;
    end
    else
    begin
      tc_r <= (txs_r == T_IDLE || t_tick) ? '0 : tc_r + 1'b1;
      txd <= txs_r == T_START ? 1'b0 : (txs_r == T_DATA ? ts_r[0] : (txs_r == T_PAR ? tp_r : 1'b1));
      case (txs_r)
        T_IDLE:
          if (ser.tx_valid)
          begin
            ts_r <= tx_m;
            tp_r <= ^tx_m;
            txs_r <= T_START;
          end
        T_START:
          if (t_tick)
          begin
            tb_r <= 4'h0;
            txs_r <= T_DATA;
          end
        T_DATA:
          if (t_tick)
          begin
            ts_r <= ts_r >> 1;
            tb_r <= tb_r + 4'h1;
            if (tb_r == nb_m1)
            begin
              tb_r <= 4'h0;
              txs_r <= ser.par_en ? T_PAR : T_STOP;
            end
          end
        T_PAR:
          if (t_tick)
            txs_r <= T_STOP;
        T_STOP:
          if (t_tick)
          begin
            tb_r <= 4'h1;
            if (!ser.stop2 || tb_r != 4'h0)
              txs_r <= T_IDLE;
          end
        default: txs_r <= T_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxs_r <= R_IDLE;
      rc_r <= '0;
      rb_r <= 4'h0;
      rs_r <= 9'h000;
      rp_r <= 1'b0;
      rdat_r <= 9'h000;
      rv_r <= 1'b0;
      rpe_r <= 1'b0;
      rfe_r <= 1'b0;
    end
    else
    begin
      rv_r <= 1'b0;
      rc_r <= (rxs_r == R_IDLE || r_tick || (rxs_r == R_START && r_half)) ? '0 : rc_r + 1'b1;
      case (rxs_r)
        R_IDLE:
          if (!rxd)
            rxs_r <= R_START;
        R_START:
          if (r_half)
          begin
            rb_r <= 4'h0;
            rxs_r <= rxd ? R_IDLE : R_DATA;
          end
        R_DATA:
          if (r_tick)
          begin
            rs_r <= {rxd, rs_r[8:1]};
            rb_r <= rb_r + 4'h1;
            if (rb_r == nb_m1)
              rxs_r <= ser.par_en ? R_PAR : R_STOP;
          end
        R_PAR:
          if (r_tick)
          begin
            rp_r <= rxd;
            rxs_r <= R_STOP;
          end
        R_STOP:
          if (r_tick)
          begin
            rv_r <= 1'b1;
            rdat_r <= rx_al;
            rfe_r <= !rxd;
            rpe_r <= ser.par_en && (rp_r != ^rx_al);
            rxs_r <= R_IDLE;
          end
        default: rxs_r <= R_IDLE;
      endcase
    end
  end
endmodule : spfc_uart
